// >>> rtl/dsle_top.sv
// Purpose : APB-controlled status LED encoder for axis and mains supply module
// Assumes : APB slave with zero wait states, 40 MHz clock
// Notes   : Unmapped addresses read zero and raise pslverr
//
// The implementer's own choices: register access over APB and the placing of the registers.
`default_nettype none

module dsle_top #(
  parameter int SLOW_HALF = dsle_pkg::DSLE_SLOW_CYC,
  parameter int FAST_HALF = dsle_pkg::DSLE_FAST_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_axis_red,
  output logic             o_axis_green,
  output logic             o_mains_red,
  output logic             o_mains_green,
  output logic             o_irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [dsle_pkg::DSLE_AX_WIDTH-1:0] axis_ctrl_reg;
  logic [dsle_pkg::DSLE_MN_WIDTH-1:0] mains_ctrl_reg;
  logic [dsle_pkg::DSLE_IRQ_W-1:0]    irq_stat_reg;
  logic [dsle_pkg::DSLE_IRQ_W-1:0]    irq_en_reg;
  logic [3:0]                         axis_mode_reg;
  logic [3:0]                         axis_mode_next;
  logic                               mains_err_seen_reg;
  dsle_pkg::dsle_pair_t               axis_pair;
  dsle_pkg::dsle_pair_t               mains_pair;
  dsle_pkg::dsle_phase_t              phase;
  dsle_pkg::dsle_mstate_t             mstate;
  logic                               wr_en;
  logic                               rd_en;
  logic                               addr_ok;
  logic [dsle_pkg::DSLE_IRQ_W-1:0]    ev;
  logic [dsle_pkg::DSLE_IRQ_W-1:0]    clr;
  logic                               ax_cfg_fault;
  logic                               ax_err_prev_reg;
  logic                               ax_def_prev_reg;
  logic                               mn_err_prev_reg;

  // Decode helper used for write strobes and read mux
  function automatic logic dsle_hit(input logic [7:0] a, input logic [7:0] ofs);
    dsle_hit = (a == ofs);
  endfunction : dsle_hit

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign wr_en    = i_psel & i_penable & i_pwrite;
  assign rd_en    = i_psel & ~i_pwrite;
  assign addr_ok  = dsle_hit(i_paddr, dsle_pkg::DSLE_AXIS_CTRL_OFS)
                  | dsle_hit(i_paddr, dsle_pkg::DSLE_MAINS_CTRL_OFS)
                  | dsle_hit(i_paddr, dsle_pkg::DSLE_LED_STAT_OFS)
                  | dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_STAT_OFS)
                  | dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_EN_OFS)
                  | dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_CLR_OFS)
                  | dsle_hit(i_paddr, dsle_pkg::DSLE_MAINS_ERR_OFS);
  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  // Control registers written by software
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      axis_ctrl_reg  <= dsle_pkg::DSLE_AX_RST;
      mains_ctrl_reg <= dsle_pkg::DSLE_MN_RST;
      irq_en_reg     <= dsle_pkg::DSLE_IRQ_RST;
    end else if (wr_en) begin
      if (dsle_hit(i_paddr, dsle_pkg::DSLE_AXIS_CTRL_OFS)) begin
        axis_ctrl_reg <= i_pwdata[dsle_pkg::DSLE_AX_WIDTH-1:0];
      end
      if (dsle_hit(i_paddr, dsle_pkg::DSLE_MAINS_CTRL_OFS)) begin
        mains_ctrl_reg <= i_pwdata[dsle_pkg::DSLE_MN_WIDTH-1:0];
      end
      if (dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_EN_OFS)) begin
        irq_en_reg <= i_pwdata[dsle_pkg::DSLE_IRQ_W-1:0];
      end
    end
  end

  // Read data registered during setup so it is stable in the access phase
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (rd_en & ~i_penable) begin
      case (1'b1)
        dsle_hit(i_paddr, dsle_pkg::DSLE_AXIS_CTRL_OFS):
          o_prdata <= {21'h0, axis_ctrl_reg};
        dsle_hit(i_paddr, dsle_pkg::DSLE_MAINS_CTRL_OFS):
          o_prdata <= {25'h0, mains_ctrl_reg};
        dsle_hit(i_paddr, dsle_pkg::DSLE_LED_STAT_OFS):
          o_prdata <= {24'h0, axis_mode_reg, o_mains_green, o_mains_red,
                       o_axis_green, o_axis_red};
        dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_STAT_OFS):
          o_prdata <= {28'h0, irq_stat_reg};
        dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_EN_OFS):
          o_prdata <= {28'h0, irq_en_reg};
        dsle_hit(i_paddr, dsle_pkg::DSLE_MAINS_ERR_OFS):
          o_prdata <= {30'h0, mains_err_seen_reg,
                       mains_ctrl_reg[dsle_pkg::DSLE_MN_ERR]};
        default:
          o_prdata <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Axis LED selection
  // ---------------------------------------------------------------
  assign ax_cfg_fault = axis_ctrl_reg[dsle_pkg::DSLE_AX_NOCFG]
                      | axis_ctrl_reg[dsle_pkg::DSLE_AX_NOFB]
                      | axis_ctrl_reg[dsle_pkg::DSLE_AX_NOPROG]
                      | axis_ctrl_reg[dsle_pkg::DSLE_AX_BADPROG]
                      | axis_ctrl_reg[dsle_pkg::DSLE_AX_HALLBAD];

  // Priority: defect, boot, config fault, errors, then power states
  always_comb begin
    axis_pair      = '{red: dsle_pkg::DSLE_OFF, green: dsle_pkg::DSLE_OFF, alt: 1'b0};
    axis_mode_next = 4'h0;
    if (axis_ctrl_reg[dsle_pkg::DSLE_AX_DEFECT]) begin
      axis_pair      = '{red: dsle_pkg::DSLE_ON, green: dsle_pkg::DSLE_ON, alt: 1'b0};
      axis_mode_next = 4'h8;
    end else if (axis_ctrl_reg[dsle_pkg::DSLE_AX_BOOT]) begin
      axis_pair.alt  = 1'b1;
      axis_mode_next = 4'h1;
    end else if (ax_cfg_fault) begin
      axis_pair.red  = dsle_pkg::DSLE_SLOW;
      axis_mode_next = 4'h2;
    end else if (axis_ctrl_reg[dsle_pkg::DSLE_AX_ERR]) begin
      if (axis_ctrl_reg[dsle_pkg::DSLE_AX_REACT2]) begin
        axis_pair.red  = dsle_pkg::DSLE_ON;
        axis_mode_next = 4'h7;
      end else begin
        axis_pair.red   = dsle_pkg::DSLE_FAST;
        axis_pair.green = dsle_pkg::DSLE_ON;
        axis_mode_next  = 4'h6;
      end
    end else if (!axis_ctrl_reg[dsle_pkg::DSLE_AX_POWERED]) begin
      axis_pair.green = dsle_pkg::DSLE_SLOW;
      axis_mode_next  = 4'h3;
    end else if (axis_ctrl_reg[dsle_pkg::DSLE_AX_CALIB]) begin
      axis_pair.green = dsle_pkg::DSLE_FAST;
      axis_mode_next  = 4'h4;
    end else begin
      axis_pair.green = dsle_pkg::DSLE_ON;
      axis_mode_next  = 4'h5;
    end
  end

  // Mode code kept for readback of the chosen indication
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      axis_mode_reg <= 4'h0;
    end else begin
      axis_mode_reg <= axis_mode_next;
    end
  end

  // ---------------------------------------------------------------
  // Mains supply module LED selection
  // ---------------------------------------------------------------
  assign mstate = dsle_pkg::dsle_mstate_t'(mains_ctrl_reg[dsle_pkg::DSLE_MN_STATE_LO +: 3]);

  // Error outranks device state; address phases only apply with no state set.
  // Red is unspecified in address phases; it is kept off there.
  always_comb begin
    mains_pair = '{red: dsle_pkg::DSLE_OFF, green: dsle_pkg::DSLE_OFF, alt: 1'b0};
    if (mains_ctrl_reg[dsle_pkg::DSLE_MN_ERR]) begin
      mains_pair.red = dsle_pkg::DSLE_ON;
    end else begin
      case (mstate)
        dsle_pkg::DSLE_MS_BOOT: begin
          mains_pair.green = dsle_pkg::DSLE_SLOW;
          mains_pair.red   = dsle_pkg::DSLE_SLOW;
        end
        dsle_pkg::DSLE_MS_INIT: begin
          mains_pair.green = dsle_pkg::DSLE_SLOW;
          mains_pair.red   = dsle_pkg::DSLE_FAST;
        end
        dsle_pkg::DSLE_MS_ERR: begin
          mains_pair.green = dsle_pkg::DSLE_SLOW;
          mains_pair.red   = dsle_pkg::DSLE_ON;
        end
        dsle_pkg::DSLE_MS_RUN: begin
          mains_pair.green = dsle_pkg::DSLE_ON;
        end
        default: begin
          if (mains_ctrl_reg[dsle_pkg::DSLE_MN_ADDR_ACT]
              | mains_ctrl_reg[dsle_pkg::DSLE_MN_WIRE_BAD]) begin
            mains_pair.green = dsle_pkg::DSLE_FAST;
          end else if (mains_ctrl_reg[dsle_pkg::DSLE_MN_ADDR_OK]) begin
            mains_pair.green = dsle_pkg::DSLE_SLOW;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Flash generation and LED outputs
  // ---------------------------------------------------------------
  dsle_flash_gen #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) u_flash (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .o_phase (phase)
  );

  dsle_led_drive u_axis_led (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pair  (axis_pair),
    .i_phase (phase),
    .o_red   (o_axis_red),
    .o_green (o_axis_green)
  );

  dsle_led_drive u_mains_led (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pair  (mains_pair),
    .i_phase (phase),
    .o_red   (o_mains_red),
    .o_green (o_mains_green)
  );

  // ---------------------------------------------------------------
  // Events and interrupt
  // ---------------------------------------------------------------
  // Previous levels for rising-edge event detection
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ax_err_prev_reg <= 1'b0;
      ax_def_prev_reg <= 1'b0;
      mn_err_prev_reg <= 1'b0;
    end else begin
      ax_err_prev_reg <= axis_ctrl_reg[dsle_pkg::DSLE_AX_ERR];
      ax_def_prev_reg <= axis_ctrl_reg[dsle_pkg::DSLE_AX_DEFECT];
      mn_err_prev_reg <= mains_ctrl_reg[dsle_pkg::DSLE_MN_ERR];
    end
  end

  assign ev[dsle_pkg::DSLE_IRQ_AX_ERR]  = axis_ctrl_reg[dsle_pkg::DSLE_AX_ERR] & ~ax_err_prev_reg;
  assign ev[dsle_pkg::DSLE_IRQ_AX_DEF]  = axis_ctrl_reg[dsle_pkg::DSLE_AX_DEFECT]
                                        & ~ax_def_prev_reg;
  assign ev[dsle_pkg::DSLE_IRQ_MN_ERR]  = mains_ctrl_reg[dsle_pkg::DSLE_MN_ERR] & ~mn_err_prev_reg;
  assign ev[dsle_pkg::DSLE_IRQ_AX_MODE] = (axis_mode_next != axis_mode_reg);
  assign clr = (wr_en & dsle_hit(i_paddr, dsle_pkg::DSLE_IRQ_CLR_OFS))
             ? i_pwdata[dsle_pkg::DSLE_IRQ_W-1:0] : 4'h0;

  // Sticky status: a new event in the clear cycle wins over the clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_stat_reg <= dsle_pkg::DSLE_IRQ_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
    end
  end

  // Latched mains error so software reads it back even if it was brief
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mains_err_seen_reg <= 1'b0;
    end else begin
      mains_err_seen_reg <= ev[dsle_pkg::DSLE_IRQ_MN_ERR]
                          | (mains_err_seen_reg & ~clr[dsle_pkg::DSLE_IRQ_MN_ERR]);
    end
  end

  assign o_irq = |(irq_stat_reg & irq_en_reg);

endmodule : dsle_top

`default_nettype wire

// >>> rtl/dsle_pkg.sv
// Purpose : Shared constants and types for the drive status LED encoder
// Assumes : 40 MHz system clock, synchronous active-high reset
// Notes   : Flash periods are not fixed by the product; defaults are plain choices
`default_nettype none

package dsle_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] DSLE_AXIS_CTRL_OFS  = 8'h00;
  localparam logic [7:0] DSLE_MAINS_CTRL_OFS = 8'h04;
  localparam logic [7:0] DSLE_LED_STAT_OFS   = 8'h08;
  localparam logic [7:0] DSLE_IRQ_STAT_OFS   = 8'h0C;
  localparam logic [7:0] DSLE_IRQ_EN_OFS     = 8'h10;
  localparam logic [7:0] DSLE_IRQ_CLR_OFS    = 8'h14;
  localparam logic [7:0] DSLE_MAINS_ERR_OFS  = 8'h18;

  // Axis control field positions
  localparam int DSLE_AX_BOOT     = 0;
  localparam int DSLE_AX_NOCFG    = 1;
  localparam int DSLE_AX_NOFB     = 2;
  localparam int DSLE_AX_NOPROG   = 3;
  localparam int DSLE_AX_BADPROG  = 4;
  localparam int DSLE_AX_HALLBAD  = 5;
  localparam int DSLE_AX_POWERED  = 6;
  localparam int DSLE_AX_CALIB    = 7;
  localparam int DSLE_AX_ERR      = 8;
  localparam int DSLE_AX_REACT2   = 9;
  localparam int DSLE_AX_DEFECT   = 10;
  localparam int DSLE_AX_WIDTH    = 11;

  // Mains control field positions
  localparam int DSLE_MN_ERR      = 0;
  localparam int DSLE_MN_ADDR_ACT = 1;
  localparam int DSLE_MN_WIRE_BAD = 2;
  localparam int DSLE_MN_ADDR_OK  = 3;
  localparam int DSLE_MN_STATE_LO = 4;
  localparam int DSLE_MN_WIDTH    = 7;

  // Reset values
  localparam logic [DSLE_AX_WIDTH-1:0] DSLE_AX_RST = 11'h001;
  localparam logic [DSLE_MN_WIDTH-1:0] DSLE_MN_RST = 7'h00;
  localparam logic [3:0]               DSLE_IRQ_RST = 4'h0;

  // Interrupt event bits
  localparam int DSLE_IRQ_AX_ERR  = 0;
  localparam int DSLE_IRQ_AX_DEF  = 1;
  localparam int DSLE_IRQ_MN_ERR  = 2;
  localparam int DSLE_IRQ_AX_MODE = 3;
  localparam int DSLE_IRQ_W       = 4;

  // Flash timing
  localparam int DSLE_CLK_HZ      = 40_000_000;
  localparam int DSLE_SLOW_MS     = 500;
  localparam int DSLE_FAST_MS     = 125;
  localparam int DSLE_SLOW_CYC    = DSLE_CLK_HZ / 1000 * DSLE_SLOW_MS;
  localparam int DSLE_FAST_CYC    = DSLE_CLK_HZ / 1000 * DSLE_FAST_MS;

  // Mains device states (3-bit field in mains control)
  typedef enum logic [2:0] {
    DSLE_MS_NONE = 3'h0,
    DSLE_MS_INIT = 3'h1,
    DSLE_MS_ERR  = 3'h2,
    DSLE_MS_RUN  = 3'h3,
    DSLE_MS_BOOT = 3'h4
  } dsle_mstate_t;

  // LED drive patterns
  typedef enum logic [1:0] {
    DSLE_OFF  = 2'h0,
    DSLE_ON   = 2'h1,
    DSLE_SLOW = 2'h2,
    DSLE_FAST = 2'h3
  } dsle_pat_t;

  // Red/green pair of patterns, plus alternate-phase flag
  typedef struct packed {
    dsle_pat_t red;
    dsle_pat_t green;
    logic      alt;
  } dsle_pair_t;

  // Flash phase carrier
  typedef struct packed {
    logic slow;
    logic fast;
  } dsle_phase_t;

endpackage : dsle_pkg

`default_nettype wire

// >>> rtl/dsle_flash_gen.sv
// Purpose : Slow and fast square-wave phases for LED flashing
// Assumes : Single clock, synchronous reset
// Notes   : Half periods are parameters so a bench can shorten them
`default_nettype none

module dsle_flash_gen #(
  parameter int SLOW_HALF = dsle_pkg::DSLE_SLOW_CYC,
  parameter int FAST_HALF = dsle_pkg::DSLE_FAST_CYC
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  output var dsle_pkg::dsle_phase_t o_phase
);

  logic [31:0] slow_cnt_reg;
  logic [31:0] fast_cnt_reg;
  logic        slow_reg;
  logic        fast_reg;

  // Separate phase flops so each counter process owns its counter and its own phase bit
  assign o_phase = '{slow: slow_reg, fast: fast_reg};

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  // Slow half-period counter toggles the slow phase
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      slow_cnt_reg <= 32'h0;
      slow_reg     <= 1'b0;
    end else if (slow_cnt_reg == 32'(SLOW_HALF - 1)) begin
      slow_cnt_reg <= 32'h0;
      slow_reg     <= ~slow_reg;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 32'h1;
    end
  end

  // Fast counter runs freely; phases need not align
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fast_cnt_reg <= 32'h0;
      fast_reg     <= 1'b0;
    end else if (fast_cnt_reg == 32'(FAST_HALF - 1)) begin
      fast_cnt_reg <= 32'h0;
      fast_reg     <= ~fast_reg;
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 32'h1;
    end
  end

endmodule : dsle_flash_gen

`default_nettype wire

// >>> rtl/dsle_led_drive.sv
// Purpose : Turns a red/green pattern pair into two registered LED levels
// Assumes : Phases come from the flash generator on the same clock
// Notes   : Alternate mode drives red on the opposite phase to green
`default_nettype none

module dsle_led_drive (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire dsle_pkg::dsle_pair_t  i_pair,
  input  wire dsle_pkg::dsle_phase_t i_phase,
  output logic                      o_red,
  output logic                      o_green
);

  // Pattern to level
  function automatic logic dsle_level(input dsle_pkg::dsle_pat_t pat,
                                      input dsle_pkg::dsle_phase_t ph);
    case (pat)
      dsle_pkg::DSLE_ON:   dsle_level = 1'b1;
      dsle_pkg::DSLE_SLOW: dsle_level = ph.slow;
      dsle_pkg::DSLE_FAST: dsle_level = ph.fast;
      default:             dsle_level = 1'b0;
    endcase
  endfunction : dsle_level

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Registered so LED pins never glitch on pattern changes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_red   <= 1'b0;
      o_green <= 1'b0;
    end else if (i_pair.alt) begin
      o_green <= i_phase.slow;
      o_red   <= ~i_phase.slow;
    end else begin
      o_red   <= dsle_level(i_pair.red, i_phase);
      o_green <= dsle_level(i_pair.green, i_phase);
    end
  end

endmodule : dsle_led_drive

`default_nettype wire

// >>> test/dsle_top_checker.sv
// Purpose : Port-level assertions for the status LED encoder
// Assumes : One clock, synchronous active-high reset
// Notes   : Bound from the bench top; sees only the top ports
`default_nettype none

module dsle_top_checker #(
  parameter int SLOW_HALF = 8,
  parameter int FAST_HALF = 2
) (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_axis_red,
  input wire logic        o_axis_green,
  input wire logic        o_mains_red,
  input wire logic        o_mains_green,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic acc;
  logic ax_wr;
  logic mn_wr;
  // A write only lands in the access cycle, so key everything on it
  assign acc   = i_psel && i_penable;
  assign ax_wr = acc && i_pwrite && i_paddr == 8'h00;
  assign mn_wr = acc && i_pwrite && i_paddr == 8'h04;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_boot_alt: assert property ($fell(i_rst) |-> ##1 (o_axis_red != o_axis_green) [*3])
    else $error("boot LEDs not alternating");
  a_cfg_fault: assert property (ax_wr && i_pwdata[10:0] == 11'h002 |-> ##2 !o_axis_green [*4])
    else $error("green lit on config fault");
  a_calib_fast: assert property (ax_wr && i_pwdata[10:0] == 11'h0C0 |->
    ##2 !o_axis_red ##[1:4] $changed(o_axis_green))
    else $error("calibration pattern wrong");
  a_axis_pwr: assert property (ax_wr && i_pwdata[10:0] == 11'h040 |->
    ##2 (o_axis_green && !o_axis_red) [*4])
    else $error("powered axis pattern wrong");
  a_err_react1: assert property (ax_wr && i_pwdata[10:0] == 11'h140 |-> ##2 o_axis_green [*4])
    else $error("green not on for reaction one");
  a_err_react2: assert property (ax_wr && i_pwdata[10:0] == 11'h300 |->
    ##2 (o_axis_red && !o_axis_green) [*4])
    else $error("reaction two pattern wrong");
  a_defect_both: assert property (ax_wr && i_pwdata[10] |-> ##2 (o_axis_red && o_axis_green) [*4])
    else $error("defect pattern wrong");
  a_mains_err: assert property (mn_wr && i_pwdata[0] |-> ##2 (o_mains_red && !o_mains_green) [*4])
    else $error("mains error pattern wrong");
  a_mains_run: assert property (mn_wr && i_pwdata[6:0] == 7'h30 |->
    ##2 (o_mains_green && !o_mains_red) [*4])
    else $error("mains run pattern wrong");
  a_unmapped_err: assert property (acc && i_paddr > 8'h18 |->
    o_pslverr && o_pready && (i_pwrite || o_prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_irq_mask: assert property (acc && i_pwrite && i_paddr == 8'h10 && i_pwdata[3:0] == 4'h0 |=>
    !o_irq)
    else $error("masked interrupt still high");
endmodule : dsle_top_checker

`default_nettype wire

// >>> test/dsle_led_eye.sv
// Purpose : Operator view of one status LED, classifies its pattern
// Assumes : Flash half periods well below the steady threshold
// Notes   : Needs two full runs after a change before its verdict holds
`default_nettype none

module dsle_led_eye #(
  parameter int STEADY = 20
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_led,
  output var dsle_pkg::dsle_pat_t o_pat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_reg;
  logic [5:0] cnt_reg;
  logic [5:0] run_reg;

  // Length of the last complete run between two level changes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      last_reg <= 1'b0;
      cnt_reg  <= 6'h00;
      run_reg  <= 6'h00;
    end else begin
      last_reg <= i_led;
      if (i_led != last_reg) begin
        run_reg <= cnt_reg + 6'h01;
        cnt_reg <= 6'h00;
      end else if (cnt_reg != 6'h3F) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  // A long quiet spell reads as steady, short runs as fast flashing
  always_comb begin
    if (cnt_reg >= 6'(STEADY)) o_pat = i_led ? dsle_pkg::DSLE_ON : dsle_pkg::DSLE_OFF;
    else if (run_reg <= 6'h03) o_pat = dsle_pkg::DSLE_FAST;
    else o_pat = dsle_pkg::DSLE_SLOW;
  end
endmodule : dsle_led_eye

`default_nettype wire

// >>> test/dsle_top_tb.sv
// Purpose : Self-checking bench for the status LED encoder
// Assumes : Short flash half periods so patterns settle quickly
// Notes   : LED patterns are judged by four operator-eye models
`default_nettype none

module dsle_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW_HALF = 8;
  localparam int FAST_HALF = 2;
  localparam dsle_pkg::dsle_pat_t P0 = dsle_pkg::DSLE_OFF;
  localparam dsle_pkg::dsle_pat_t P1 = dsle_pkg::DSLE_ON;
  localparam dsle_pkg::dsle_pat_t PS = dsle_pkg::DSLE_SLOW;
  localparam dsle_pkg::dsle_pat_t PF = dsle_pkg::DSLE_FAST;
  logic i_mclk = 1'b0, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, axr, axg, mnr, mng, irq;
  dsle_pkg::dsle_pat_t axr_pat, axg_pat, mnr_pat, mng_pat;
  int bad_count = 0, compares = 0, cycles = 0;

  // ---------------------------------------------------------------
  // Clock, timeout, design and eyes
  // ---------------------------------------------------------------
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  dsle_top #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) dsle_top_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_axis_red(axr), .o_axis_green(axg), .o_mains_red(mnr),
    .o_mains_green(mng), .o_irq(irq));
  dsle_led_eye dsle_led_eye_i0 (.i_mclk(i_mclk), .i_rst(i_rst), .i_led(axr), .o_pat(axr_pat));
  dsle_led_eye dsle_led_eye_i1 (.i_mclk(i_mclk), .i_rst(i_rst), .i_led(axg), .o_pat(axg_pat));
  dsle_led_eye dsle_led_eye_i2 (.i_mclk(i_mclk), .i_rst(i_rst), .i_led(mnr), .o_pat(mnr_pat));
  dsle_led_eye dsle_led_eye_i3 (.i_mclk(i_mclk), .i_rst(i_rst), .i_led(mng), .o_pat(mng_pat));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; idles a cycle first so strobes never double up
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1) @(posedge i_mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Write a control word, let five slow runs (40 cycles) pass, judge the pair
  task led(input logic [7:0] a, input logic [31:0] d, input dsle_pkg::dsle_pat_t er,
           input dsle_pkg::dsle_pat_t eg, input logic use_r);
    apb(1'b1, a, d);
    repeat (40) @(posedge i_mclk);
    if (use_r) chk(32'(a == 8'h00 ? axr_pat : mnr_pat), 32'(er));
    chk(32'(a == 8'h00 ? axg_pat : mng_pat), 32'(eg));
  endtask : led

  task end_of_test();
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h1);
    led(8'h00, 32'h001, PS, PS, 1'b1);
    for (int b = 1; b <= 5; b++) led(8'h00, 32'(1 << b), PS, P0, 1'b1);
    led(8'h00, 32'h000, P0, PS, 1'b1);
    led(8'h00, 32'h0C0, P0, PF, 1'b1);
    led(8'h00, 32'h040, P0, P1, 1'b1);
    led(8'h00, 32'h140, PF, P1, 1'b1);
    led(8'h00, 32'h300, P1, P0, 1'b1);
    apb(1'b0, 8'h08, 32'h0); chk(rd, 32'h71);
    led(8'h00, 32'h7FF, P1, P1, 1'b1);
    led(8'h04, 32'h02, P0, PF, 1'b0);
    led(8'h04, 32'h04, P0, PF, 1'b0);
    led(8'h04, 32'h08, P0, PS, 1'b0);
    led(8'h04, 32'h10, PF, PS, 1'b1);
    led(8'h04, 32'h20, P1, PS, 1'b1);
    led(8'h04, 32'h30, P0, P1, 1'b1);
    led(8'h04, 32'h40, PS, PS, 1'b1);
    led(8'h04, 32'h31, P1, P0, 1'b1);
    apb(1'b0, 8'h18, 32'h0); chk(rd, 32'h3);
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'hF);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h10, 32'h4); repeat (2) @(posedge i_mclk); chk(32'(irq), 32'h1);
    apb(1'b1, 8'h10, 32'h0); repeat (2) @(posedge i_mclk); chk(32'(irq), 32'h0);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h04, 32'h30);
    apb(1'b1, 8'h14, 32'h4); repeat (2) @(posedge i_mclk); chk(32'(irq), 32'h0);
    apb(1'b0, 8'h18, 32'h0); chk(rd, 32'h0);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF); chk(32'(err), 32'h1);
    apb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    end_of_test();
  end
endmodule : dsle_top_tb

bind dsle_top dsle_top_checker #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) dsle_top_checker_i (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_axis_red(o_axis_red), .o_axis_green(o_axis_green),
  .o_mains_red(o_mains_red), .o_mains_green(o_mains_green), .o_irq(o_irq));

`default_nettype wire
